// file: dps_host.sv
`timescale 1ns/1ps
// host model: select, stoppable link clock, bytes
module dps_host
  import dps_pkg::*;
(
  // host drive
  output logic                   selN,
  output logic                   busClockTrue,
  output logic                   busClockComp,
  output logic      [BYTE_W-1:0] dqIn,
  output logic                   strobeMaskIn,
  // device drive
  input  wire logic [BYTE_W-1:0] dqOut,
  input  wire logic              dqOe,
  input  wire logic              strobeMaskOut,
  input  wire logic              strobeMaskOe
);
  logic [7:0] hDq = 8'h00;
  logic       hOe = 1'b0;
  logic       hMk = 1'b0;
  logic       flag = 1'b0;
  int         edgeNo = 0;
  int         strobeBad = 0;
  // released lines show the inverse of the last value
  assign dqIn = dqOe ? dqOut : (hOe ? hDq : ~hDq);
  assign strobeMaskIn = strobeMaskOe ? strobeMaskOut : (hOe ? hMk : ~hMk);
  assign busClockComp = ~busClockTrue;
  initial selN = 1'b1;
  initial busClockTrue = 1'b0;
  // half period: data centred, then the clock toggles
  task automatic half(input logic [7:0] d, input logic m);
    hDq = d;
    hMk = m;
    #1.5;
    busClockTrue = ~busClockTrue;
    if (busClockTrue) edgeNo++;
    #1.5;
  endtask
  // select on idle clock, nb command bytes, then latency
  task automatic start(input logic [47:0] ca, input int lat, input int nb);
    int k0;
    #(1.8 - $realtime + 1.5 * $floor($realtime / 1.5));
    selN = 1'b0;
    hOe = 1'b1;
    edgeNo = 0;
    #1.5;
    flag = strobeMaskIn;
    for (int i = 5; i > 5 - nb; i--) half(ca[i*8 +: 8], 1'b0);
    hOe = 1'b0;
    if (nb < 6) return;
    k0 = flag ? 4 + 2 * lat : 4 + lat;
    while (edgeNo < k0 - 1) begin
      half(hDq, 1'b0);
      half(hDq, 1'b0);
    end
  endtask
  // write word, mask bit high keeps that byte
  task automatic wr(input logic [15:0] w, input logic [1:0] m);
    hOe = 1'b1;
    half(w[15:8], m[1]);
    half(w[7:0], m[0]);
  endtask
  // read word, strobe must copy the clock
  task automatic rd(output logic [15:0] w);
    half(hDq, 1'b0);
    w[15:8] = dqIn;
    if (strobeMaskIn !== 1'b1) strobeBad++;
    half(hDq, 1'b0);
    w[7:0] = dqIn;
    if (strobeMaskIn !== 1'b0) strobeBad++;
  endtask
  // deselect with the clock low, then stay idle about four core periods
  // so the core side takes each descriptor before the next one comes
  task automatic stop();
    #1.5;
    selN = 1'b1;
    hOe = 1'b0;
    #400;
  endtask
endmodule // dps_host

// file: dps_pkg.sv
package dps_pkg;

  // command-address framing
  localparam int CA_CYCLES  = 3;   // clock cycles of command-address
  localparam int CA_BITS    = 48;  // whole command-address width
  localparam int BYTE_W     = 8;   // link data width
  localparam int WORD_W     = 16;  // word carried per clock cycle
  localparam int ADDR_FULL  = 32;  // row, upper and lower column together

  // command-address field positions
  localparam int CA_BIT_DIR   = 47;  // 1 read, 0 write
  localparam int CA_BIT_SPACE = 46;  // 0 array, 1 register space
  localparam int CA_BIT_BURST = 45;  // 0 wrapped, 1 linear
  localparam int CA_ROW_HI    = 44;
  localparam int CA_ROW_LO    = 16;
  localparam int CA_COL_HI    = 2;
  localparam int CA_COL_LO    = 0;

  // cycle counter of the link side
  localparam int CYC_W = 8;
  localparam logic [CYC_W-1:0] CYC_MAX  = 8'hFF;
  localparam logic [CYC_W-1:0] CYC_ZERO = 8'h00;
  localparam logic [CYC_W-1:0] CYC_ONE  = 8'h01;
  localparam logic [CYC_W-1:0] CYC_TWO  = 8'h02;
  localparam logic [CYC_W-1:0] CYC_CA   = 8'h03;

  // default initial access latency in bus clock cycles
  localparam int LAT_DEFAULT = 6;

  // register space word indices
  localparam logic [2:0] REG_ID_IDX  = 3'h0;
  localparam logic [2:0] REG_CFG_IDX = 3'h1;

  // configuration register layout
  localparam int          CFG_WRAP_LSB   = 0;
  localparam int          CFG_WRAP_W     = 2;
  localparam logic [15:0] CFG_RESET      = 16'h0000;
  localparam int          WRAP_MIN_WORDS = 8;  // 16 bytes, doubled per step

endpackage

// file: dps_slave.sv
`timescale 1ns/1ps

module dps_slave
  import dps_pkg::*;
#(
  parameter int          LAT_CYCLES = LAT_DEFAULT,
  parameter int          ADDR_W     = 6,
  parameter logic [15:0] DEV_ID     = 16'h5A3C  // arbitrary value
) (
  // core clock and hardware reset pin
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  // link clock and select
  input  wire logic                 busClockTrue,
  input  wire logic                 busClockComp,
  input  wire logic                 selN,
  // data lines
  input  wire logic [BYTE_W-1:0]    dqIn,
  output logic      [BYTE_W-1:0]    dqOut,
  output logic                      dqOe,
  // strobe and mask line
  input  wire logic                 strobeMaskIn,
  output logic                      strobeMaskOut,
  output logic                      strobeMaskOe,
  // core side status
  input  wire logic                 refreshNeed,
  output logic                      linkBusy,
  output logic                      cmdValid,
  output logic                      cmdRead,
  output logic                      cmdRegSpace,
  output logic                      cmdLinear,
  output logic      [ADDR_FULL-1:0] cmdAddr
);

  // elaboration checks
  if (LAT_CYCLES < 2 || 2 * LAT_CYCLES + CA_CYCLES + 1 > 250) begin : g_lat
    $error("dps_slave: LAT_CYCLES out of range");
  end
  if (ADDR_W < 3 || ADDR_W > 16) begin : g_aw
    $error("dps_slave: ADDR_W out of range");
  end

  localparam logic [CYC_W-1:0] K0_SHORT =
    CYC_W'(CA_CYCLES + 1 + LAT_CYCLES);
  localparam logic [CYC_W-1:0] K0_LONG =
    CYC_W'(CA_CYCLES + 1 + 2 * LAT_CYCLES);

  // next word of a burst, wrapped within the configured group or linear
  function automatic logic [ADDR_FULL-1:0] advance(
    input logic [ADDR_FULL-1:0]  a,
    input logic                  linear,
    input logic [CFG_WRAP_W-1:0] sel
  );
    logic [ADDR_FULL-1:0] m;
    m = ADDR_FULL'(WRAP_MIN_WORDS) << sel;
    m = m - 32'h0000_0001;
    if (linear) begin
      advance = a + 32'h0000_0001;
    end else begin
      advance = (a & ~m) | ((a + 32'h0000_0001) & m);
    end
  endfunction

  // word address held in a command-address
  function automatic logic [ADDR_FULL-1:0] startOf(
    input logic [CA_BITS-1:0] c
  );
    startOf = {c[CA_ROW_HI:CA_ROW_LO], c[CA_COL_HI:CA_COL_LO]};
  endfunction

  logic                    linkRstn;
  logic                    wrClk;
  logic [CYC_W-1:0]        cyc;
  logic [23:0]             caEven;
  logic [23:0]             caOdd;
  logic [CA_BITS-1:0]      ca;
  logic [CA_BITS-1:0]      caNow;
  logic                    isRead;
  logic                    isReg;
  logic                    isLinear;
  logic                    refreshSync;
  logic                    extraLat;
  logic [CYC_W-1:0]        k0;
  logic [ADDR_FULL-1:0]    curAddr;
  logic [ADDR_FULL-1:0]    xferAddr;
  logic [WORD_W-1:0]       ramRdata;
  logic [WORD_W-1:0]       regWordQ;
  logic [WORD_W-1:0]       wordOut;
  logic [BYTE_W-1:0]       hiQ;
  logic                    maskHiQ;
  logic                    readWin;
  logic                    writeWin;
  logic                    ramWe;
  logic                    cfgWe;
  logic [WORD_W-1:0]       cfg;
  logic [CFG_WRAP_W-1:0]   wrapSel;
  logic                    descToggle;
  logic                    descRead;
  logic                    descReg;
  logic                    descLinear;
  logic [ADDR_FULL-1:0]    descAddr;
  logic                    togSync;
  logic                    togSeen;

  // link state lives only while selected and out of hardware reset
  assign linkRstn = rstn & ~selN;
  // the true clock edge is the crossing point; complement is redundant
  assign wrClk    = ~busClockTrue;

  // refresh demand carried into the link domain
  dps_sync2 u_sync_refresh (
    .clk  (busClockTrue),
    .rstn (rstn),
    .din  (refreshNeed),
    .dout (refreshSync)
  );

  // clock cycle counter, frozen while the clock stops
  always_ff @(posedge busClockTrue or negedge linkRstn) begin
    if (!linkRstn) begin
      cyc <= CYC_ZERO;
    end else if (cyc != CYC_MAX) begin
      cyc <= cyc + CYC_ONE;
    end
  end

  // command-address bytes on rising edges
  always_ff @(posedge busClockTrue or negedge linkRstn) begin
    if (!linkRstn) begin
      caEven <= 24'h00_0000;
    end else begin
      unique case (cyc)
        CYC_ZERO: caEven[23:16] <= dqIn;
        CYC_ONE:  caEven[15:8]  <= dqIn;
        CYC_TWO:  caEven[7:0]   <= dqIn;
        default:  caEven        <= caEven;
      endcase
    end
  end

  // command-address bytes on falling edges
  always_ff @(negedge busClockTrue or negedge linkRstn) begin
    if (!linkRstn) begin
      caOdd <= 24'h00_0000;
    end else begin
      unique case (cyc)
        CYC_ONE: caOdd[23:16] <= dqIn;
        CYC_TWO: caOdd[15:8]  <= dqIn;
        CYC_CA:  caOdd[7:0]   <= dqIn;
        default: caOdd        <= caOdd;
      endcase
    end
  end

  // command-address assembled high byte first
  assign ca = {caEven[23:16], caOdd[23:16], caEven[15:8],
               caOdd[15:8], caEven[7:0], caOdd[7:0]};
  assign caNow    = {ca[CA_BITS-1:BYTE_W], dqIn};
  assign isRead   = ca[CA_BIT_DIR];
  assign isReg    = ca[CA_BIT_SPACE];
  assign isLinear = ca[CA_BIT_BURST];
  assign wrapSel  = cfg[CFG_WRAP_LSB +: CFG_WRAP_W];

  // refresh penalty decided as the first clock edge arrives
  always_ff @(posedge busClockTrue or negedge linkRstn) begin
    if (!linkRstn) begin
      extraLat <= 1'b0;
    end else if (cyc == CYC_ZERO) begin
      extraLat <= refreshSync;
    end
  end

  // first data cycle, doubled latency under refresh
  assign k0 = extraLat ? K0_LONG : K0_SHORT;

  // read pointer runs two words ahead of the transfer
  always_ff @(posedge busClockTrue or negedge linkRstn) begin
    if (!linkRstn) begin
      curAddr <= '0;
    end else if (cyc < k0 - CYC_TWO) begin
      curAddr <= startOf(ca);
    end else begin
      curAddr <= advance(curAddr, isLinear, wrapSel);
    end
  end

  // address of the word on the link this cycle
  always_ff @(posedge busClockTrue or negedge linkRstn) begin
    if (!linkRstn) begin
      xferAddr <= '0;
    end else if (cyc < k0) begin
      xferAddr <= startOf(ca);
    end else begin
      xferAddr <= advance(xferAddr, isLinear, wrapSel);
    end
  end

  // register space read word, aligned with the array read
  always_ff @(posedge busClockTrue or negedge linkRstn) begin
    if (!linkRstn) begin
      regWordQ <= 16'h0000;
    end else if (curAddr[2:0] == REG_CFG_IDX) begin
      regWordQ <= cfg;
    end else if (curAddr[2:0] == REG_ID_IDX) begin
      regWordQ <= DEV_ID;
    end else begin
      regWordQ <= 16'h0000;
    end
  end

  // whole word latched for both edges of its cycle
  always_ff @(posedge busClockTrue or negedge linkRstn) begin
    if (!linkRstn) begin
      wordOut <= 16'h0000;
    end else if (isRead && cyc >= k0 - CYC_ONE) begin
      wordOut <= isReg ? regWordQ : ramRdata;
    end
  end

  // write high byte and its mask on the rising edge
  always_ff @(posedge busClockTrue or negedge linkRstn) begin
    if (!linkRstn) begin
      hiQ     <= 8'h00;
      maskHiQ <= 1'b1;
    end else if (!isRead && cyc >= k0 - CYC_ONE) begin
      hiQ     <= dqIn;
      maskHiQ <= strobeMaskIn;
    end
  end

  // data windows
  assign readWin  = isRead && cyc >= k0 && cyc != CYC_ZERO;
  assign writeWin = !isRead && cyc >= k0 && cyc != CYC_ZERO;
  // word committed on the falling edge that completes it
  assign ramWe = writeWin && !isReg;
  assign cfgWe = writeWin && isReg && xferAddr[2:0] == REG_CFG_IDX;

  // array window of the memory
  dps_word_ram #(
    .DW (WORD_W),
    .AW (ADDR_W)
  ) u_ram (
    .wrClk (wrClk),
    .we    (ramWe),
    .be    ({~maskHiQ, ~strobeMaskIn}),
    .waddr (xferAddr[ADDR_W-1:0]),
    .wdata ({hiQ, dqIn}),
    .rdClk (busClockTrue),
    .raddr (curAddr[ADDR_W-1:0]),
    .rdata (ramRdata)
  );

  // configuration register, kept across transactions
  always_ff @(negedge busClockTrue or negedge rstn) begin
    if (!rstn) begin
      cfg <= CFG_RESET;
    end else if (cfgWe) begin
      if (!maskHiQ) begin
        cfg[15:8] <= hiQ;
      end
      if (!strobeMaskIn) begin
        cfg[7:0] <= dqIn;
      end
    end
  end

  // descriptor published when the sixth byte lands
  always_ff @(negedge busClockTrue or negedge rstn) begin
    if (!rstn) begin
      descToggle <= 1'b0;
      descRead   <= 1'b0;
      descReg    <= 1'b0;
      descLinear <= 1'b0;
      descAddr   <= '0;
    end else if (linkRstn && cyc == CYC_CA) begin
      descToggle <= ~descToggle;
      descRead   <= caNow[CA_BIT_DIR];
      descReg    <= caNow[CA_BIT_SPACE];
      descLinear <= caNow[CA_BIT_BURST];
      descAddr   <= startOf(caNow);
    end
  end

  // pin drive: double-rate data from a word register
  assign dqOut = busClockTrue ? wordOut[15:8] : wordOut[7:0];
  assign dqOe  = linkRstn && readWin;
  // strobe out during command-address and for the whole of a read
  assign strobeMaskOe = linkRstn && (cyc <= CYC_CA || isRead);
  always_comb begin
    if (cyc == CYC_ZERO) begin
      strobeMaskOut = refreshSync;
    end else if (cyc <= CYC_CA) begin
      strobeMaskOut = extraLat;
    end else begin
      strobeMaskOut = readWin && busClockTrue;
    end
  end

  // select state and descriptor event into the core domain
  dps_sync2 u_sync_busy (
    .clk  (ref_clk),
    .rstn (rstn),
    .din  (~selN),
    .dout (linkBusy)
  );

  dps_sync2 u_sync_tog (
    .clk  (ref_clk),
    .rstn (rstn),
    .din  (descToggle),
    .dout (togSync)
  );

  // toggle edge detect
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      togSeen <= 1'b0;
    end else begin
      togSeen <= togSync;
    end
  end

  // descriptor capture, held until the next command
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmdValid    <= 1'b0;
      cmdRead     <= 1'b0;
      cmdRegSpace <= 1'b0;
      cmdLinear   <= 1'b0;
      cmdAddr     <= '0;
    end else begin
      cmdValid <= togSync ^ togSeen;
      if (togSync ^ togSeen) begin
        cmdRead     <= descRead;
        cmdRegSpace <= descReg;
        cmdLinear   <= descLinear;
        cmdAddr     <= descAddr;
      end
    end
  end

endmodule // dps_slave

// file: dps_slave_assertions.sv
`timescale 1ns/1ps
// framing checks at the slave ports
module dps_chk
  import dps_pkg::*;
(
  // clocks and reset
  input wire logic              ref_clk,
  input wire logic              rstn,
  input wire logic              busClockTrue,
  // link
  input wire logic              selN,
  input wire logic [BYTE_W-1:0] dqIn,
  input wire logic              dqOe,
  input wire logic              strobeMaskOut,
  input wire logic              strobeMaskOe,
  // core side
  input wire logic              linkBusy,
  input wire logic              cmdValid
);
  logic [7:0] edges;
  logic       dirRd;
  // rising link edges since select
  always_ff @(posedge busClockTrue or posedge selN or negedge rstn) begin
    if (!rstn) edges <= 8'h00;
    else if (selN) edges <= 8'h00;
    else if (edges != 8'hFF) edges <= edges + 8'h01;
  end
  // direction bit of the first byte
  always_ff @(posedge busClockTrue or negedge rstn) begin
    if (!rstn) dirRd <= 1'b0;
    else if (edges == 8'h00) dirRd <= dqIn[7];
  end
  sequence selHeld;
    $fell(selN) ##1 !selN [*2];
  endsequence
  sequence selGone;
    $rose(selN) ##1 selN [*2];
  endsequence
  busy_on_select_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      selHeld |-> linkBusy) else $error("busy missing");
  busy_drop_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      selGone |-> !linkBusy) else $error("busy stuck");
  idle_quiet_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      selN |-> !dqOe && !strobeMaskOe) else $error("drive while idle");
  reset_quiet_a:
    assert property (@(posedge ref_clk)
      !rstn |-> !dqOe && !strobeMaskOe) else $error("drive in reset");
  strobe_in_ca_a:
    assert property (@(posedge busClockTrue) disable iff (!rstn)
      !selN && edges < 8'h03 |-> strobeMaskOe) else $error("no flag");
  flag_held_a:
    assert property (@(posedge busClockTrue) disable iff (!rstn)
      !selN && edges inside {8'h01, 8'h02} |-> $stable(strobeMaskOut))
      else $error("flag moved");
  no_early_data_a:
    assert property (@(posedge busClockTrue) disable iff (!rstn)
      !selN && edges < 8'h04 |-> !dqOe) else $error("early data");
  write_release_a:
    assert property (@(posedge busClockTrue) disable iff (!rstn)
      !selN && edges >= 8'h04 && !dirRd |-> !dqOe && !strobeMaskOe)
      else $error("drive in write");
  cmd_pulse_a:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      cmdValid |=> !cmdValid) else $error("long descriptor pulse");
endmodule // dps_chk

bind dps_slave dps_chk CHK (
  .ref_clk(ref_clk), .rstn(rstn), .busClockTrue(busClockTrue),
  .selN(selN), .dqIn(dqIn), .dqOe(dqOe), .strobeMaskOut(strobeMaskOut),
  .strobeMaskOe(strobeMaskOe), .linkBusy(linkBusy), .cmdValid(cmdValid)
);

// file: dps_sync2.sv
`timescale 1ns/1ps

// two flip-flop level synchroniser
module dps_sync2 (
  // destination clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // level in and out
  input  wire logic din,
  output logic      dout
);

  logic meta;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // dps_sync2

// file: dps_word_ram.sv
`timescale 1ns/1ps

// word store: write port and registered read port on separate clocks
module dps_word_ram #(
  parameter int DW = 16,
  parameter int AW = 6
) (
  // write port
  input  wire logic          wrClk,
  input  wire logic          we,
  input  wire logic [1:0]    be,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port
  input  wire logic          rdClk,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  localparam int HALF = DW / 2;

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // byte-enabled write
  always_ff @(posedge wrClk) begin
    if (we && be[1]) begin
      mem[waddr][DW-1:HALF] <= wdata[DW-1:HALF];
    end
    if (we && be[0]) begin
      mem[waddr][HALF-1:0] <= wdata[HALF-1:0];
    end
  end

  // registered read
  always_ff @(posedge rdClk) begin
    rdata <= mem[raddr];
  end

endmodule // dps_word_ram

// file: tb_top.sv
`timescale 1ns/1ps
// bench for the slave framing block
module tb_top;
  import dps_pkg::*;
  localparam int          LAT = 3;
  localparam logic [15:0] ID  = 16'hC0DE; // arbitrary value
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        refreshNeed = 1'b0;
  logic        selN, busClockTrue, busClockComp, dqOe, strobeMaskIn;
  logic        strobeMaskOut, strobeMaskOe, linkBusy, cmdValid;
  logic        cmdRead, cmdRegSpace, cmdLinear;
  logic [7:0]  dqIn, dqOut;
  logic [31:0] cmdAddr;
  logic [15:0] w;
  int          err_total = 0;
  int          checks_done = 0;
  always #50 ref_clk = ~ref_clk;
  dps_host HOST (.selN(selN), .busClockTrue(busClockTrue),
    .busClockComp(busClockComp), .dqIn(dqIn), .strobeMaskIn(strobeMaskIn),
    .dqOut(dqOut), .dqOe(dqOe), .strobeMaskOut(strobeMaskOut),
    .strobeMaskOe(strobeMaskOe));
  dps_slave #(.LAT_CYCLES(LAT), .DEV_ID(ID)) DUT (.ref_clk(ref_clk),
    .rstn(rstn), .busClockTrue(busClockTrue), .busClockComp(busClockComp),
    .selN(selN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .strobeMaskIn(strobeMaskIn), .strobeMaskOut(strobeMaskOut),
    .strobeMaskOe(strobeMaskOe), .refreshNeed(refreshNeed),
    .linkBusy(linkBusy), .cmdValid(cmdValid), .cmdRead(cmdRead),
    .cmdRegSpace(cmdRegSpace), .cmdLinear(cmdLinear), .cmdAddr(cmdAddr));
  // compare and count
  task automatic cmp(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask
  // verdict
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait for the descriptor, link clock stopped
  task automatic waitCmd();
    for (int n = 0; cmdValid !== 1'b1; n++) begin
      if (n > 20) begin
        err_total++;
        $display("wrong value at %0t: no descriptor", $time);
        results();
      end
      @(posedge ref_clk);
      #1.3;
    end
  endtask
  function automatic logic [47:0] ca(input logic r, s, l, logic [31:0] a);
    return {r, s, l, a[31:3], 13'h0000, a[2:0]};
  endfunction
  // read burst with a clock pause after the first word
  task automatic rdSeq(input logic [47:0] c, logic [15:0] e0, e1, e2, int n);
    HOST.start(c, LAT, 6);
    cmp(HOST.flag, refreshNeed, "flag");
    for (int i = 0; i < n; i++) begin
      HOST.rd(w);
      cmp(w, i == 0 ? e0 : i == 1 ? e1 : e2, "word");
      if (i == 0) #249;
    end
    HOST.stop();
  endtask
  // write burst, mask on the first word only
  task automatic wrSeq(input logic [47:0] c, logic [15:0] w0, w1, w2,
                       logic [1:0] m);
    HOST.start(c, LAT, 6);
    HOST.wr(w0, m);
    HOST.wr(w1, 2'b00);
    if (w2 !== 16'h0000) HOST.wr(w2, 2'b00);
    HOST.stop();
  endtask
  // partial command dropped, then every kind decoded
  task automatic tDecode();
    logic [31:0] a;
    HOST.start(ca(1'b1, 1'b1, 1'b1, 32'hFFFFFFFF), LAT, 2);
    HOST.stop();
    repeat (8) begin
      @(posedge ref_clk);
      #1.3;
      cmp(cmdValid, 1'b0, "partial");
    end
    for (int i = 0; i < 8; i++) begin
      a = 32'h9ABCDEF0 + 32'(i) * 32'h13579BDF;
      HOST.start(ca(i[2], i[1], i[0], a), LAT, 6);
      waitCmd();
      cmp({cmdRead, cmdRegSpace, cmdLinear}, i[2:0], "kind");
      cmp(cmdAddr, a, "address");
      cmp(linkBusy, 1'b1, "busy");
      HOST.stop();
    end
    $display("decode done");
  endtask
  // array bursts, register space and wrap size
  task automatic tData();
    @(negedge ref_clk);
    refreshNeed = 1'b1;
    wrSeq(ca(1'b0, 1'b0, 1'b1, 32'h6), 16'h1A2B, 16'h3C4D, 16'h5E6F, 2'b00);
    wrSeq(ca(1'b0, 1'b0, 1'b0, 32'h7), 16'h7788, 16'h99AA, 16'h0000, 2'b01);
    rdSeq(ca(1'b1, 1'b0, 1'b0, 32'h6), 16'h1A2B, 16'h774D, 16'h99AA, 3);
    rdSeq(ca(1'b1, 1'b0, 1'b1, 32'h7), 16'h774D, 16'h5E6F, 16'h0000, 2);
    rdSeq(ca(1'b1, 1'b1, 1'b0, 32'h0), ID, 16'h0000, 16'h0000, 1);
    wrSeq(ca(1'b0, 1'b1, 1'b0, 32'h1), 16'h0001, 16'h0000, 16'h0000, 2'b00);
    rdSeq(ca(1'b1, 1'b1, 1'b0, 32'h1), 16'h0001, 16'h0000, 16'h0000, 1);
    rdSeq(ca(1'b1, 1'b0, 1'b0, 32'h6), 16'h1A2B, 16'h774D, 16'h5E6F, 3);
    $display("data done");
  endtask
  // abort mid-burst, reset mid-read
  task automatic tAbort();
    HOST.start(ca(1'b1, 1'b0, 1'b1, 32'h6), LAT, 6);
    HOST.rd(w);
    HOST.stop();
    cmp({dqOe, strobeMaskOe}, 2'b00, "deselect");
    HOST.start(ca(1'b1, 1'b0, 1'b1, 32'h6), LAT, 6);
    HOST.rd(w);
    @(negedge ref_clk);
    rstn = 1'b0;
    refreshNeed = 1'b0;
    #1;
    cmp({dqOe, strobeMaskOe}, 2'b00, "reset drive");
    HOST.stop();
    @(negedge ref_clk);
    rstn = 1'b1;
    @(posedge ref_clk);
    rdSeq(ca(1'b1, 1'b1, 1'b0, 32'h1), 16'h0000, 16'h0000, 16'h0000, 1);
    cmp(HOST.strobeBad, 32'h0, "strobe");
    $display("abort done");
  endtask
  // main sequence
  initial begin
    repeat (12) @(negedge ref_clk);
    cmp({dqOe, strobeMaskOe, cmdValid, linkBusy}, 4'h0, "rst");
    cmp(cmdAddr, 32'h0, "rst addr");
    rstn = 1'b1;
    @(posedge ref_clk);
    #1.3;
    tDecode();
    tData();
    tAbort();
    results();
  end
endmodule // tb_top
